/* rtl/aisc_ctrl.sv */
/*
  Host-visible control and interrupt logic of the accessory detector:
  identification, control, two read-clear flag registers, one mask
  register, switch closure sequencing and ID conversion pacing.
  Assumes a serial slave engine on the same clock drives the byte
  register port, and detection logic gives one-cycle event pulses.
*/
// Behaviour
// - Unblocked: drive interrupts, closure timed by hold.
// - Blocked: pin low, no closing except test cable.
// - Control resets to 1F, upper bits zero.
// - Hold 0: wait, close on host writing 1.
// - Hold 1: close after programmed delay.
// - Delay 10 ms plus 20 ms per code.
// - Source bit picks manual or detected settings.
// - Release 0 forces every switch open.
// - Report select 0: periodic conversion, flag changes.
// - Wake field sets conversion interval 50-1000 ms.
// - Report select 1: key monitor, key events.
// - Flags1 bits 0-4: attach, detach, key events.
// - Flags1 bits 5-7: overvoltage, overtemp, cleared.
// - Flags2 bits 0-1: charger on AV, unknown.
// - Flags2 bit 2: conversion change, select 0 only.
// - Flags2 bits 3-4 stuck key; 7-5 zero.
// - Mask1 bit suppresses same flag's interrupt; resets zero.
// - Identity read-only: maker low, revision high.
`include "aisc_consts.svh"
`default_nettype none
module aisc_ctrl #(
  parameter int TICK_CYCLES = `AISC_TICK_CYCLES,
  // Arbitrary identity values
  parameter logic [2:0] MAKER_CODE    = 3'h5,
  parameter logic [4:0] REVISION_CODE = 5'h0B
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // Byte register port from serial engine
  input  wire logic [7:0]      regAddr,
  input  wire logic            regWr,
  input  wire logic            regRd,
  input  wire logic [7:0]      regWrData,
  output var  logic [7:0]      regRdData,
  // Detection side
  input  wire aisc_pkg::evt_t  evIn,
  input  wire logic            idDone,
  input  wire logic            factoryTestCable,
  input  wire logic [3:0]      wakeCode,
  input  wire logic [3:0]      swWaitCode,
  input  wire logic            idValid,
  input  wire logic [4:0]      idResult,
  // Switch settings
  input  wire logic [7:0]      manualSel,
  input  wire logic [7:0]      autoSel,
  // Outputs
  output var  logic            irqOutPin,
  output var  logic [7:0]      switchCtl,
  output var  logic            idConvStart,
  output var  logic            keyMonitorEn
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // Registers
  aisc_pkg::ctrl_t    ctrl_q;      // Control
  logic [7:0]         flags1_q;    // Primary flags
  logic [4:0]         flags2_q;    // Secondary flags
  logic [7:0]         mask1_q;     // Primary suppress mask
  logic [7:0]         rdData_q;    // Read data
  logic               irq_q;       // Pin level
  logic [7:0]         sw_q;        // Switch drive
  logic               conv_q;      // Conversion start pulse
  logic               keyEn_q;     // Key monitor enable
  logic [4:0]         lastId_q;    // Last conversion result
  aisc_pkg::sw_state_t state_q;    // Closure sequencer
  aisc_pkg::sw_state_t state_d;
  logic [TW-1:0]      swPre_q;     // Delay prescaler
  logic [6:0]         swCnt_q;     // Delay ticks left
  logic [TW-1:0]      wkPre_q;     // Wake prescaler
  logic [6:0]         wkCnt_q;     // Wake ticks done

  // Address decode
  wire hitIdent = (regAddr == `AISC_ADDR_IDENT);
  wire hitCtrl  = (regAddr == `AISC_ADDR_CTRL);
  wire hitF1    = (regAddr == `AISC_ADDR_FLAGS1);
  wire hitF2    = (regAddr == `AISC_ADDR_FLAGS2);
  wire hitM1    = (regAddr == `AISC_ADDR_MASK1);
  wire wrCtrl   = regWr & hitCtrl;
  wire wrM1     = regWr & hitM1;
  wire rdF1     = regRd & hitF1;
  wire rdF2     = regRd & hitF2;

  // Identity word, fixed
  wire [7:0] identWord = {REVISION_CODE, MAKER_CODE};

  // Read mux, unmapped offsets read zero
  wire [7:0] rdMux =
    hitIdent ? identWord :
    hitCtrl  ? ctrl_q :
    hitF1    ? flags1_q :
    hitF2    ? {3'h0, flags2_q} :
    hitM1    ? mask1_q : 8'h00;

  // Key events only counted in key monitor mode
  wire keyMode = ctrl_q.rawSel;

  // Primary event vector in flag order
  wire [7:0] set1 = {
    evIn.faultCleared,
    evIn.overTemp,
    evIn.overvoltage,
    evIn.longRelease & keyMode,
    evIn.longPress & keyMode,
    evIn.keyPress & keyMode,
    evIn.detach,
    evIn.attach};

  // Conversion change detect, only in periodic mode
  wire idChange = idValid & ~ctrl_q.rawSel & (idResult != lastId_q);

  // Secondary event vector in flag order
  wire [4:0] set2 = {
    evIn.stuckKeyCleared,
    evIn.stuckKey,
    idChange,
    evIn.unknownAttach,
    evIn.avCharger};

  // Set wins over read clear
  wire [7:0] flags1_d = (flags1_q & ~{8{rdF1}}) | set1;
  wire [4:0] flags2_d = (flags2_q & ~{5{rdF2}}) | set2;

  // Pending unmasked flags; no second mask here
  wire pend = |(flags1_q & ~mask1_q) | (|flags2_q);

  // Control write keeps reserved bits zero
  wire [7:0] ctrl_d = wrCtrl ? {3'h0, regWrData[4:0]} : ctrl_q;

  // Delay in ticks: 1 + 2*code, code clamped
  wire [3:0] swCode = (swWaitCode > `AISC_SWD_MAXCODE) ?
                      `AISC_SWD_MAXCODE : swWaitCode;
  wire [6:0] swTicks = `AISC_SWD_BASE + {2'h0, swCode, 1'b0};

  // Wake interval table in ticks
  function automatic logic [6:0] wakeTicks(input logic [3:0] c);
    logic [6:0] t;
    t = 7'h64;
    unique case (c)
      4'h0: t = 7'h05;
      4'h1: t = 7'h0A;
      4'h2: t = 7'h0F;
      4'h3: t = 7'h14;
      4'h4: t = 7'h1E;
      4'h5: t = 7'h28;
      4'h6: t = 7'h32;
      4'h7: t = 7'h3C;
      4'h8: t = 7'h46;
      4'h9: t = 7'h50;
      4'hA: t = 7'h5A;
      default: t = 7'h64;  // Above table: longest
    endcase
    return t;
  endfunction

  wire [6:0] wkTarget = wakeTicks(wakeCode);

  // Prescaler wraps
  wire swTick = (swPre_q == TW'(TICK_CYCLES - 1));
  wire wkTick = (wkPre_q == TW'(TICK_CYCLES - 1));
  wire wkDone = wkTick & (wkCnt_q + 7'h01 >= wkTarget);

  // Delay expiry: last tick of last count
  wire swExpire = swTick & (swCnt_q == 7'h01);

  // Closure sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      aisc_pkg::SW_IDLE: begin
        if (idDone) begin
          // Hold bit picks timed or host-gated
          state_d = ctrl_q.hold ? aisc_pkg::SW_DELAY
                                : aisc_pkg::SW_HOST;
        end
      end
      aisc_pkg::SW_DELAY: begin
        if (!ctrl_q.hold) begin
          state_d = aisc_pkg::SW_HOST;
        end else if (swExpire) begin
          state_d = aisc_pkg::SW_CLOSED;
        end
      end
      aisc_pkg::SW_HOST: begin
        if (ctrl_q.hold) begin
          state_d = aisc_pkg::SW_CLOSED;
        end
      end
      aisc_pkg::SW_CLOSED: begin
        state_d = state_q;
      end
    endcase
    // Detach always reopens
    if (evIn.detach) begin
      state_d = aisc_pkg::SW_IDLE;
    end
  end

  // Switch drive: release, block and source gating
  wire swAllowed = ctrl_q.swRelease &
                   (~ctrl_q.block | factoryTestCable) &
                   (state_q == aisc_pkg::SW_CLOSED);
  wire [7:0] swSel = ctrl_q.src ? autoSel : manualSel;
  wire [7:0] sw_d  = swAllowed ? swSel : 8'h00;

  // Register file
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q   <= `AISC_CTRL_RESET;
      mask1_q  <= `AISC_MASK_RESET;
      flags1_q <= `AISC_FLAG_RESET;
      flags2_q <= 5'h00;
      rdData_q <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      mask1_q  <= wrM1 ? regWrData : mask1_q;
      flags1_q <= flags1_d;
      flags2_q <= flags2_d;
      rdData_q <= regRd ? rdMux : rdData_q;
    end
  end

  // Pin and mode outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_q   <= 1'b0;
      sw_q    <= 8'h00;
      keyEn_q <= 1'b1;
    end else begin
      irq_q   <= ~ctrl_q.block & pend;
      sw_q    <= sw_d;
      keyEn_q <= ctrl_q.rawSel;
    end
  end

  // Sequencer and delay counter; prescaler restarts for a full first tick
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= aisc_pkg::SW_IDLE;
      swPre_q <= '0;
      swCnt_q <= 7'h00;
    end else begin
      state_q <= state_d;
      if (state_q != aisc_pkg::SW_DELAY) begin
        swPre_q <= '0;
        swCnt_q <= swTicks;
      end else begin
        swPre_q <= swTick ? '0 : swPre_q + TW'(1);
        swCnt_q <= swTick ? swCnt_q - 7'h01 : swCnt_q;
      end
    end
  end

  // Periodic conversion pacing, only in periodic mode
  always_ff @(posedge clk) begin
    if (reset || ctrl_q.rawSel) begin
      wkPre_q <= '0;
      wkCnt_q <= 7'h00;
      conv_q  <= 1'b0;
    end else begin
      wkPre_q <= wkTick ? '0 : wkPre_q + TW'(1);
      wkCnt_q <= wkDone ? 7'h00 : (wkTick ? wkCnt_q + 7'h01 : wkCnt_q);
      conv_q  <= wkDone;
    end
  end

  // Last conversion result for change compare
  always_ff @(posedge clk) begin
    if (reset) begin
      lastId_q <= `AISC_ID_RESET;
    end else if (idValid) begin
      lastId_q <= idResult;
    end
  end

  assign regRdData    = rdData_q;
  assign irqOutPin    = irq_q;
  assign switchCtl    = sw_q;
  assign idConvStart  = conv_q;
  assign keyMonitorEn = keyEn_q;

  // Checks
  a_ctrl_reset: assert property (@(posedge clk)
    $past(reset) && !reset |-> ctrl_q == `AISC_CTRL_RESET)
    else $error("control not at reset value");

  a_irq_blocked: assert property (@(posedge clk) disable iff (reset)
    ctrl_q.block |=> !irqOutPin)
    else $error("interrupt pin active while blocked");

  a_irq_pending: assert property (@(posedge clk) disable iff (reset)
    !ctrl_q.block && |(flags1_q & ~mask1_q) |=> irqOutPin)
    else $error("unmasked flag did not raise pin");

  a_attach_flag: assert property (@(posedge clk) disable iff (reset)
    evIn.attach |=> flags1_q[0])
    else $error("attach flag not set");

  a_read_clear: assert property (@(posedge clk) disable iff (reset)
    rdF1 && set1 == 8'h00 |=> flags1_q == 8'h00 && regRdData == $past(flags1_q))
    else $error("primary flags not cleared by read");

  a_ident_read: assert property (@(posedge clk) disable iff (reset)
    regRd && hitIdent |=> regRdData == {REVISION_CODE, MAKER_CODE})
    else $error("identity read wrong");

  a_release_open: assert property (@(posedge clk) disable iff (reset)
    !ctrl_q.swRelease |=> switchCtl == 8'h00)
    else $error("switches closed while released");

  a_manual_src: assert property (@(posedge clk) disable iff (reset)
    swAllowed && !ctrl_q.src |=> switchCtl == $past(manualSel))
    else $error("manual settings not followed");

  a_host_close: assert property (@(posedge clk) disable iff (reset)
    state_q == aisc_pkg::SW_HOST && ctrl_q.hold && !evIn.detach
      |=> state_q == aisc_pkg::SW_CLOSED)
    else $error("no immediate close on hold write");

  a_adc_gated: assert property (@(posedge clk) disable iff (reset)
    ctrl_q.rawSel && !flags2_q[2] |=> !flags2_q[2])
    else $error("conversion change flagged in key mode");

  a_key_mode: assert property (@(posedge clk) disable iff (reset)
    ctrl_q.rawSel ##1 ctrl_q.rawSel |-> keyMonitorEn && !idConvStart)
    else $error("key mode outputs wrong");
endmodule
`default_nettype wire

/* rtl/aisc_consts.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  accessory interrupt and switch control block.
  Assumes a 250 MHz system clock.
*/
`ifndef AISC_CONSTS_SVH
`define AISC_CONSTS_SVH

// Register offsets on the byte register port
`define AISC_ADDR_IDENT   8'h01
`define AISC_ADDR_CTRL    8'h02
`define AISC_ADDR_FLAGS1  8'h03
`define AISC_ADDR_FLAGS2  8'h04
`define AISC_ADDR_MASK1   8'h05

// Reset values
`define AISC_CTRL_RESET   8'h1F
`define AISC_FLAG_RESET   8'h00
`define AISC_MASK_RESET   8'h00
`define AISC_ID_RESET     5'h1F

// Identification fields, positions and widths
`define AISC_MAKER_LSB    0
`define AISC_MAKER_W      3
`define AISC_REV_LSB      3
`define AISC_REV_W        5

// Secondary flag width, bits above read zero
`define AISC_SEC_W        5

// Timing: base tick and derived cycle count
`define AISC_CLK_NS       4
`define AISC_TICK_MS      10
`define AISC_TICK_CYCLES  ((`AISC_TICK_MS * 1000000) / `AISC_CLK_NS)

// Switching delay: 10 ms plus 20 ms per code step, in ticks
`define AISC_SWD_BASE     7'h01
`define AISC_SWD_MAXCODE  4'hA

`endif

/* rtl/aisc_pkg.sv */
/*
  Types of the accessory interrupt and switch control block.
  Assumes aisc_consts.svh for all numeric values.
*/
`default_nettype none
package aisc_pkg;
  // Control register fields, msb first
  typedef struct packed {
    logic [2:0] rsvd;
    logic       swRelease; // 0 forces all switches open
    logic       rawSel;   // 1 key monitor, 0 periodic conversion
    logic       src;      // 1 automatic, 0 manual
    logic       hold;     // 1 timed close, 0 wait for host
    logic       block;    // master interrupt block
  } ctrl_t;

  // Event pulses from detection logic
  typedef struct packed {
    logic faultCleared;
    logic overTemp;
    logic overvoltage;
    logic longRelease;
    logic longPress;
    logic keyPress;
    logic detach;
    logic attach;
    logic stuckKeyCleared;
    logic stuckKey;
    logic unknownAttach;
    logic avCharger;
  } evt_t;

  // Switch closure sequencing, Gray along the path
  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_DELAY  = 2'b01,
    SW_CLOSED = 2'b11,
    SW_HOST   = 2'b10
  } sw_state_t;
endpackage
`default_nettype wire

/* tb/aisc_host.sv */
/*
  Host model: single-byte accesses on the block's register port.
  Assumes the testbench owns clk and calls wr and rd by hierarchy.
*/
`default_nettype none
module aisc_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic [7:0] regAddr,
  output var  logic       regWr,
  output var  logic       regRd,
  output var  logic [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port from time zero
  initial begin
    regAddr   = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
    regWrData = 8'h00;
  end
  // One write; data flips afterwards so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr     <= 1'b0;
    regWrData <= ~d;
  endtask
  // One read; callers touch flag registers only once unblocked
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
  Self-checking bench of the accessory interrupt and switch control.
  Assumes aisc_pkg, aisc_consts.svh and the host model are compiled.
*/
`include "aisc_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and detection-side stimulus
  logic           clk = 1'b0;
  logic           reset = 1'b1;
  aisc_pkg::evt_t evIn = '0;
  logic           idDone = 1'b0;
  logic           idValid = 1'b0;
  logic [4:0]     idResult = 5'h1F;
  logic [3:0]     wakeCode = 4'h0;
  logic [3:0]     swWaitCode = 4'h1;
  logic [7:0]     manualSel = 8'h3C;
  logic [7:0]     autoSel = 8'hA5;
  logic           factoryTestCable = 1'b0;
  // Port wires and bookkeeping
  logic [7:0]     regAddr, regWrData, regRdData, switchCtl, rdv;
  logic           regWr, regRd, irqOutPin, idConvStart, keyMonitorEn;
  int             err_total = 0;
  int             cmp_count = 0;
  int             n;
  always #2 clk = ~clk;
  aisc_host host (.clk(clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData));
  // Short tick keeps delays to a few cycles; identity values arbitrary
  aisc_ctrl #(.TICK_CYCLES(4), .MAKER_CODE(3'h6), .REVISION_CODE(5'h0D)) dut (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData), .evIn(evIn), .idDone(idDone),
    .factoryTestCable(factoryTestCable), .wakeCode(wakeCode), .swWaitCode(swWaitCode),
    .idValid(idValid), .idResult(idResult), .manualSel(manualSel), .autoSel(autoSel),
    .irqOutPin(irqOutPin), .switchCtl(switchCtl), .idConvStart(idConvStart),
    .keyMonitorEn(keyMonitorEn));
  // Verdict, the only exit
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Byte or pin comparison
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdv);
    chk($sformatf("register %h", a), e, rdv);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // One-cycle event pulse; flag is set by the time this returns
  task automatic ev(input aisc_pkg::evt_t e);
    @(posedge clk);
    evIn <= e;
    @(posedge clk);
    evIn <= '0;
    #1;
  endtask
  task automatic identified;
    @(posedge clk);
    idDone <= 1'b1;
    @(posedge clk);
    idDone <= 1'b0;
  endtask
  task automatic newResult(input logic [4:0] r);
    @(posedge clk);
    idResult <= r;
    idValid  <= 1'b1;
    @(posedge clk);
    idValid <= 1'b0;
  endtask
  // Bounded waits; running out is a mismatch and ends the run
  task automatic waitSw(input logic [7:0] e);
    n = 0;
    while (switchCtl !== e && n < 100) begin
      cyc(1);
      n++;
    end
    chk("switchCtl", e, switchCtl);
    // Only a real timeout ends the run early
    if (switchCtl !== e) end_of_test();
  endtask
  task automatic waitConv;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (idConvStart !== 1'b1 && n < 200);
    if (idConvStart !== 1'b1) begin
      chk("idConvStart", 8'h01, 8'h00);
      end_of_test();
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("irqOutPin", 8'h00, {7'h00, irqOutPin});
    chk("keyMonitorEn", 8'h01, {7'h00, keyMonitorEn});
    rdchk(`AISC_ADDR_IDENT, 8'h6E);
    rdchk(`AISC_ADDR_CTRL, 8'h1F);
    rdchk(`AISC_ADDR_MASK1, 8'h00);
    host.wr(`AISC_ADDR_IDENT, 8'h00);
    rdchk(`AISC_ADDR_IDENT, 8'h6E);
    host.wr(`AISC_ADDR_CTRL, 8'hFF);
    rdchk(`AISC_ADDR_CTRL, 8'h1F);
    rdchk(8'h30, 8'h00);
    // Blocked: event flagged but pin stays low
    ev(12'h010);
    cyc(2);
    chk("irqOutPin", 8'h00, {7'h00, irqOutPin});
    host.wr(`AISC_ADDR_CTRL, 8'h1E);
    cyc(2);
    chk("irqOutPin", 8'h01, {7'h00, irqOutPin});
    rdchk(`AISC_ADDR_FLAGS1, 8'h01);
    cyc(1);
    chk("irqOutPin", 8'h00, {7'h00, irqOutPin});
    rdchk(`AISC_ADDR_FLAGS1, 8'h00);
    // Every flag position of both registers except secondary bit 2
    for (int i = 0; i < 8; i++) begin
      ev(12'h010 << i);
      rdchk(`AISC_ADDR_FLAGS1, 8'h01 << i);
    end
    for (int j = 0; j < 4; j++) begin
      ev(12'h001 << j);
      rdchk(`AISC_ADDR_FLAGS2, 8'h01 << (j + (j > 1)));
    end
    // Masked flag keeps the pin low but stays readable
    host.wr(`AISC_ADDR_MASK1, 8'h01);
    rdchk(`AISC_ADDR_MASK1, 8'h01);
    ev(12'h010);
    cyc(2);
    chk("irqOutPin", 8'h00, {7'h00, irqOutPin});
    rdchk(`AISC_ADDR_FLAGS1, 8'h01);
    host.wr(`AISC_ADDR_MASK1, 8'h00);
    // Periodic conversion mode: key events ignored, changes flagged
    host.wr(`AISC_ADDR_CTRL, 8'h16);
    cyc(2);
    chk("keyMonitorEn", 8'h00, {7'h00, keyMonitorEn});
    ev(12'h040);
    rdchk(`AISC_ADDR_FLAGS1, 8'h00);
    newResult(5'h03);
    rdchk(`AISC_ADDR_FLAGS2, 8'h04);
    newResult(5'h03);
    rdchk(`AISC_ADDR_FLAGS2, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      wakeCode <= i ? 4'h4 : 4'h0;
      waitConv();
      waitConv();
      chk("conversion interval", i ? 8'h78 : 8'h14, n[7:0]);
    end
    host.wr(`AISC_ADDR_CTRL, 8'h1E);
    newResult(5'h07);
    rdchk(`AISC_ADDR_FLAGS2, 8'h00);
    // Timed closure, then source and release control
    identified();
    cyc(8);
    chk("switchCtl", 8'h00, switchCtl);
    waitSw(autoSel);
    // Code 1 is 30 ms, three ticks of 4 cycles: closed 5 cycles after the early look
    chk("closure delay", 8'h05, n[7:0]);
    host.wr(`AISC_ADDR_CTRL, 8'h1A);
    waitSw(manualSel);
    host.wr(`AISC_ADDR_CTRL, 8'h0A);
    waitSw(8'h00);
    host.wr(`AISC_ADDR_CTRL, 8'h1A);
    waitSw(manualSel);
    ev(12'h020);
    waitSw(8'h00);
    // Host-gated closure
    host.wr(`AISC_ADDR_CTRL, 8'h18);
    identified();
    cyc(30);
    chk("switchCtl", 8'h00, switchCtl);
    host.wr(`AISC_ADDR_CTRL, 8'h1A);
    cyc(2);
    chk("switchCtl", manualSel, switchCtl);
    // Blocked: no closure except for a test cable
    ev(12'h020);
    host.wr(`AISC_ADDR_CTRL, 8'h1B);
    identified();
    cyc(40);
    chk("switchCtl", 8'h00, switchCtl);
    @(posedge clk);
    factoryTestCable <= 1'b1;
    waitSw(manualSel);
    // Mid-run reset restores control and mask defaults
    host.wr(`AISC_ADDR_MASK1, 8'hA5);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("irqOutPin", 8'h00, {7'h00, irqOutPin});
    rdchk(`AISC_ADDR_CTRL, 8'h1F);
    rdchk(`AISC_ADDR_MASK1, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
